// >>> ecp_top.v
// Functional notes
// RULE1 - Capture latches counter on qualifying input edge
// RULE2 - One mode bit selects capture or PWM
// RULE3 - PWM mode counter counts up only
// RULE4 - Timestamp one period, timestamp two compare
// RULE5 - Timestamps three, four shadow period, compare
// RULE6 - Both modes share four timestamp registers
// RULE7 - Sync input loads counter; sync output driven
// RULE8 - All events merged onto one interrupt
// RULE9 - Nothing advances while clock enable low
// RULE10 - Source holds capture pulse at least two cycles
// RULE11 - Captures rotate through four registers, flag each
`include "ecp_consts.vh"

module ecp_top (
   // Clock and reset
   input  wire                     CLOCK,
   input  wire                     SYS_RST,
   // System control gate
   input  wire                     CLK_ENABLE,
   // Mode and capture control
   input  wire                     MODE_SELECT_BIT,
   input  wire                     CAPTURE_FALLING,
   input  wire                     EVENT_IN,
   // Counter synchronisation
   input  wire                     SYNC_ENABLE,
   input  wire [`ECP_CNT_W-1:0]    SYNC_PHASE,
   input  wire                     COUNTER_SYNC_INPUT,
   output reg                      COUNTER_SYNC_OUTPUT,
   // Shadow load for PWM mode
   input  wire                     SHADOW_WRITE,
   input  wire [`ECP_CNT_W-1:0]    SHADOW_PERIOD,
   input  wire [`ECP_CNT_W-1:0]    SHADOW_COMPARE,
   // Interrupt control
   input  wire [`ECP_NUM_FLAGS-1:0] INT_MASK,
   input  wire [`ECP_NUM_FLAGS-1:0] FLAG_CLEAR,
   output reg  [`ECP_NUM_FLAGS-1:0] EVENT_FLAGS,
   output reg                      CHANNEL_INTERRUPT,
   // Status and data
   output wire [`ECP_CNT_W-1:0]    COUNTER_VALUE,
   output reg  [`ECP_IDX_W-1:0]    CAPTURE_INDEX,
   output wire [`ECP_CNT_W-1:0]    TIMESTAMP_REG_1,
   output wire [`ECP_CNT_W-1:0]    TIMESTAMP_REG_2,
   output wire [`ECP_CNT_W-1:0]    TIMESTAMP_REG_3,
   output wire [`ECP_CNT_W-1:0]    TIMESTAMP_REG_4,
   output reg                      AUXILIARY_PWM_OUTPUT
);

   // ----------------------------------------
   // Event input edges
   // ----------------------------------------
   wire evt_rise;
   wire evt_fall;

   ecp_edge_sync u_sync (
      .CLOCK   (CLOCK),
      .SYS_RST (SYS_RST),
      .ENABLE  (CLK_ENABLE),
      .PIN_IN  (EVENT_IN),
      .RISE    (evt_rise),
      .FALL    (evt_fall)
   );

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   wire                  pwm_mode;
   wire                  cap_mode;
   wire                  cap_evt;
   wire                  sync_hit;
   reg  [`ECP_CNT_W-1:0] cnt_q;
   reg  [`ECP_CNT_W-1:0] ts_q [0:`ECP_NUM_TS-1];
   wire                  prd_hit;
   wire                  cmp_hit;
   wire                  ovf_hit;

   assign pwm_mode = MODE_SELECT_BIT;                                 // [RULE2]
   assign cap_mode = ~MODE_SELECT_BIT;                                // [RULE2]
   // Pulses shorter than the qualifier window are not seen
   assign cap_evt  = cap_mode & (CAPTURE_FALLING ? evt_fall : evt_rise); // [RULE1] [RULE10]
   assign sync_hit = SYNC_ENABLE & COUNTER_SYNC_INPUT;
   assign prd_hit  = pwm_mode & (cnt_q >= ts_q[0]);                   // [RULE4]
   assign cmp_hit  = pwm_mode & (cnt_q == ts_q[1]);                   // [RULE4]
   assign ovf_hit  = cap_mode & (cnt_q == `ECP_CNT_MAX);

   assign COUNTER_VALUE   = cnt_q;
   assign TIMESTAMP_REG_1 = ts_q[0];
   assign TIMESTAMP_REG_2 = ts_q[1];
   assign TIMESTAMP_REG_3 = ts_q[2];
   assign TIMESTAMP_REG_4 = ts_q[3];

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always @(posedge CLOCK) begin
      if (SYS_RST) begin
         cnt_q <= `ECP_CNT_RST;
      end else if (CLK_ENABLE) begin                                  // [RULE9]
         if (sync_hit) begin
            cnt_q <= SYNC_PHASE;                                      // [RULE7]
         end else if (prd_hit) begin
            cnt_q <= `ECP_CNT_RST;                                    // [RULE3]
         end else begin
            cnt_q <= cnt_q + 32'h00000001;                            // [RULE3]
         end
      end
   end

   // ----------------------------------------
   // Sync output
   // ----------------------------------------
   always @(posedge CLOCK) begin
      if (SYS_RST) begin
         COUNTER_SYNC_OUTPUT <= 1'b0;
      end else if (CLK_ENABLE) begin
         COUNTER_SYNC_OUTPUT <= sync_hit | prd_hit | ovf_hit;         // [RULE7]
      end else begin
         COUNTER_SYNC_OUTPUT <= 1'b0;
      end
   end

   // ----------------------------------------
   // Capture pointer
   // ----------------------------------------
   always @(posedge CLOCK) begin
      if (SYS_RST) begin
         CAPTURE_INDEX <= `ECP_IDX_RST;
      end else if (CLK_ENABLE && cap_evt) begin
         CAPTURE_INDEX <= CAPTURE_INDEX + 2'h1;                       // [RULE11]
      end
   end

   // ----------------------------------------
   // Shared timestamp registers
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < `ECP_NUM_TS; i = i + 1) begin : g_ts
         always @(posedge CLOCK) begin
            if (SYS_RST) begin
               ts_q[i] <= `ECP_TS_RST;
            end else if (CLK_ENABLE) begin                            // [RULE9]
               if (cap_evt && (CAPTURE_INDEX == i)) begin
                  ts_q[i] <= cnt_q;                                   // [RULE1] [RULE6] [RULE11]
               end else if (pwm_mode && prd_hit && (i < 2)) begin
                  ts_q[i] <= ts_q[(i + 2) % `ECP_NUM_TS];             // [RULE5] [RULE6]
               end else if (pwm_mode && SHADOW_WRITE && (i == 2)) begin
                  ts_q[i] <= SHADOW_PERIOD;                           // [RULE5]
               end else if (pwm_mode && SHADOW_WRITE && (i == 3)) begin
                  ts_q[i] <= SHADOW_COMPARE;                          // [RULE5]
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // PWM output
   // ----------------------------------------
   always @(posedge CLOCK) begin
      if (SYS_RST) begin
         AUXILIARY_PWM_OUTPUT <= 1'b0;
      end else if (CLK_ENABLE) begin
         if (cap_mode) begin
            AUXILIARY_PWM_OUTPUT <= 1'b0;                             // [RULE2]
         end else if (prd_hit) begin
            AUXILIARY_PWM_OUTPUT <= (ts_q[3] != `ECP_CNT_RST);        // [RULE3]
         end else if (cmp_hit) begin
            AUXILIARY_PWM_OUTPUT <= 1'b0;                             // [RULE4]
         end
      end
   end

   // ----------------------------------------
   // Event flags and interrupt
   // ----------------------------------------
   wire [`ECP_NUM_FLAGS-1:0] flag_set;

   generate
      for (i = 0; i < `ECP_NUM_TS; i = i + 1) begin : g_cset
         assign flag_set[`ECP_FLG_CEVT1 + i] = cap_evt & (CAPTURE_INDEX == i); // [RULE11]
      end
   endgenerate
   assign flag_set[`ECP_FLG_OVF] = ovf_hit;
   assign flag_set[`ECP_FLG_PRD] = prd_hit;
   assign flag_set[`ECP_FLG_CMP] = cmp_hit;

   generate
      for (i = 0; i < `ECP_NUM_FLAGS; i = i + 1) begin : g_flag
         always @(posedge CLOCK) begin
            if (SYS_RST) begin
               EVENT_FLAGS[i] <= 1'b0;
            end else if (CLK_ENABLE) begin                            // [RULE9]
               // Set beats a clear in the same cycle
               if (flag_set[i]) begin
                  EVENT_FLAGS[i] <= 1'b1;                             // [RULE8]
               end else if (FLAG_CLEAR[i]) begin
                  EVENT_FLAGS[i] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   always @(posedge CLOCK) begin
      if (SYS_RST) begin
         CHANNEL_INTERRUPT <= 1'b0;
      end else if (CLK_ENABLE) begin
         CHANNEL_INTERRUPT <= |(EVENT_FLAGS & INT_MASK);              // [RULE8]
      end
   end

endmodule

// >>> ecp_consts.vh
`ifndef ECP_CONSTS_VH
`define ECP_CONSTS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define ECP_CNT_W        32
`define ECP_NUM_TS       4
`define ECP_IDX_W        2
`define ECP_NUM_FLAGS    7

// ----------------------------------------
// Event flag positions
// ----------------------------------------
`define ECP_FLG_CEVT1    0
`define ECP_FLG_CEVT4    3
`define ECP_FLG_OVF      4
`define ECP_FLG_PRD      5
`define ECP_FLG_CMP      6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ECP_CNT_RST      32'h00000000
`define ECP_TS_RST       32'h00000000
`define ECP_IDX_RST      2'h0
`define ECP_FLAGS_RST    7'h00
`define ECP_CNT_MAX      32'hFFFFFFFF

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define ECP_SYNC_STAGES  3
`define ECP_MIN_PULSE_CYC 2

`endif

// >>> ecp_edge_sync.v
`include "ecp_consts.vh"

module ecp_edge_sync (
   // Clock and reset
   input  wire CLOCK,
   input  wire SYS_RST,
   input  wire ENABLE,
   // Pin side
   input  wire PIN_IN,
   // Edge pulses
   output reg  RISE,
   output reg  FALL
);

   // ----------------------------------------
   // Three-stage synchroniser
   // ----------------------------------------
   reg ff1_q;
   reg ff2_q;
   reg ff3_q;
   reg level_q;

   always @(posedge CLOCK) begin
      if (SYS_RST) begin
         ff1_q   <= 1'b0;
         ff2_q   <= 1'b0;
         ff3_q   <= 1'b0;
         level_q <= 1'b0;
         RISE    <= 1'b0;
         FALL    <= 1'b0;
      end else if (ENABLE) begin
         ff1_q <= PIN_IN;
         ff2_q <= ff1_q;
         ff3_q <= ff2_q;
         RISE  <= 1'b0;
         FALL  <= 1'b0;
         // Change counts once stages two and three agree
         if ((ff2_q == ff3_q) && (ff3_q != level_q)) begin
            level_q <= ff3_q;
            RISE    <= ff3_q;
            FALL    <= ~ff3_q;
         end
      end else begin
         RISE <= 1'b0;
         FALL <= 1'b0;
      end
   end

endmodule

// >>> ecp_event_src.sv
module ecp_event_src (
   // Clock
   input  logic clk,
   // Event pin
   output logic event_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial event_pin = 1'b0;
   // Idle level, gap, then an active level held for width cycles
   task automatic pulse(input logic idle, input int width, input int gap);
      if (width < 2) width = 2;
      if (event_pin !== idle) event_pin = idle;
      repeat (gap) @(negedge clk);
      event_pin = ~idle;
      repeat (width) @(negedge clk);
      event_pin = idle;
   endtask
endmodule

// >>> ecp_assertions.sv
module ecp_checker (
   // Clock and controls
   input logic        CLOCK,
   input logic        SYS_RST,
   input logic        CLK_ENABLE,
   input logic        MODE_SELECT_BIT,
   input logic        SYNC_ENABLE,
   input logic        COUNTER_SYNC_INPUT,
   input logic [31:0] SYNC_PHASE,
   input logic [6:0]  INT_MASK,
   // Outputs
   input logic        COUNTER_SYNC_OUTPUT,
   input logic [6:0]  EVENT_FLAGS,
   input logic        CHANNEL_INTERRUPT,
   input logic [31:0] COUNTER_VALUE,
   input logic [1:0]  CAPTURE_INDEX,
   input logic [31:0] TIMESTAMP_REG_1,
   input logic [31:0] TIMESTAMP_REG_2,
   input logic [31:0] TIMESTAMP_REG_3,
   input logic [31:0] TIMESTAMP_REG_4,
   input logic        AUXILIARY_PWM_OUTPUT
);
   logic [1:0] rst_q;
   wire        sy = SYNC_ENABLE & COUNTER_SYNC_INPUT & CLK_ENABLE;
   wire        ok = (rst_q == 2'h0);
   always @(posedge CLOCK) rst_q <= SYS_RST ? 2'h3 : {rst_q[0], 1'b0};
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   a_irq_follows_flags: assert property (ok && $past(CLK_ENABLE)
      |-> CHANNEL_INTERRUPT == |($past(EVENT_FLAGS & INT_MASK))) else $error("irq wrong");
   a_pwm_off_capture: assert property (ok && !$past(MODE_SELECT_BIT) && $past(CLK_ENABLE)
      |-> !AUXILIARY_PWM_OUTPUT) else $error("pwm in capture");
   a_count_up_free: assert property (ok && $past(CLK_ENABLE & ~MODE_SELECT_BIT & ~sy)
      |-> COUNTER_VALUE == $past(COUNTER_VALUE) + 32'h1) else $error("count wrong");
   a_hold_when_gated: assert property (ok && !$past(CLK_ENABLE) |-> $stable(COUNTER_VALUE)
      && $stable(CAPTURE_INDEX) && $stable(TIMESTAMP_REG_1)) else $error("moved while gated");
   a_sync_load_out: assert property (ok && $past(sy) |-> COUNTER_VALUE == $past(SYNC_PHASE)
      ##[0:1] COUNTER_SYNC_OUTPUT) else $error("sync wrong");
   a_period_reload: assert property (MODE_SELECT_BIT && CLK_ENABLE && !sy
      && COUNTER_VALUE >= TIMESTAMP_REG_1 |=> COUNTER_VALUE == 32'h0 && TIMESTAMP_REG_1
      == $past(TIMESTAMP_REG_3) && TIMESTAMP_REG_2 == $past(TIMESTAMP_REG_4)) else $error("period wrong");
   a_index_rotates: assert property (ok && CAPTURE_INDEX != $past(CAPTURE_INDEX)
      |-> CAPTURE_INDEX == $past(CAPTURE_INDEX) + 2'h1 && EVENT_FLAGS[$past(CAPTURE_INDEX)])
      else $error("index wrong");
   a_stamp_first: assert property (ok && $past(CAPTURE_INDEX) == 2'h0 && CAPTURE_INDEX == 2'h1
      |-> TIMESTAMP_REG_1 == $past(COUNTER_VALUE)) else $error("stamp wrong");
endmodule

bind ecp_top ecp_checker i_chk (.CLOCK, .SYS_RST, .CLK_ENABLE, .MODE_SELECT_BIT, .SYNC_ENABLE,
   .COUNTER_SYNC_INPUT, .SYNC_PHASE, .INT_MASK, .COUNTER_SYNC_OUTPUT, .EVENT_FLAGS, .CHANNEL_INTERRUPT,
   .COUNTER_VALUE, .CAPTURE_INDEX, .TIMESTAMP_REG_1, .TIMESTAMP_REG_2, .TIMESTAMP_REG_3,
   .TIMESTAMP_REG_4, .AUXILIARY_PWM_OUTPUT);

// >>> ecp_tb.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, rst = 1'b1, clk_en = 1'b1, mode = 1'b0, fall = 1'b0;
   logic        sync_en = 1'b1, sync_in = 1'b0, shw = 1'b0;
   logic [31:0] phase = 32'h0, sh_per = 32'h0, sh_cmp = 32'h0;
   logic [6:0]  mask = 7'h0F, clr = 7'h00;
   wire         ev, sync_out, irq, pwm;
   wire [6:0]   flags;
   wire [1:0]   idx;
   wire [31:0]  cnt;
   wire [31:0]  ts [4];
   int          errors = 0, checks_done = 0;
   always #5 clk = ~clk;
   ecp_event_src i_src (.clk(clk), .event_pin(ev));
   ecp_top i_dut (.CLOCK(clk), .SYS_RST(rst), .CLK_ENABLE(clk_en), .MODE_SELECT_BIT(mode),
      .CAPTURE_FALLING(fall), .EVENT_IN(ev), .SYNC_ENABLE(sync_en), .SYNC_PHASE(phase),
      .COUNTER_SYNC_INPUT(sync_in), .COUNTER_SYNC_OUTPUT(sync_out), .SHADOW_WRITE(shw),
      .SHADOW_PERIOD(sh_per), .SHADOW_COMPARE(sh_cmp), .INT_MASK(mask), .FLAG_CLEAR(clr),
      .EVENT_FLAGS(flags), .CHANNEL_INTERRUPT(irq), .COUNTER_VALUE(cnt), .CAPTURE_INDEX(idx),
      .TIMESTAMP_REG_1(ts[0]), .TIMESTAMP_REG_2(ts[1]), .TIMESTAMP_REG_3(ts[2]),
      .TIMESTAMP_REG_4(ts[3]), .AUXILIARY_PWM_OUTPUT(pwm));
   // ---------------------------
   // Helpers
   // ---------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ---------------------------
   // Scenarios
   // ---------------------------
   task automatic t_capture(input logic pol, input int s);
      fall = pol;
      mask = 7'h0F;
      cyc(2);
      for (int k = 0; k < 5; k++) i_src.pulse(pol, 4, 4);
      cyc(8);
      for (int j = 2; j < 5; j++) check(ts[(s + j) % 4] - ts[(s + j - 1) % 4], 32'h8);
      check(idx, (s + 5) % 4);
      check(flags[3:0], 4'hF);
      check(irq, 1'b1);
      clr = 7'h7F;
      cyc(1);
      clr = 7'h00;
      cyc(2);
      check(flags, 7'h00);
      check(irq, 1'b0);
   endtask
   task automatic t_sync_gate();
      phase = 32'h100;
      sync_in = 1'b1;
      cyc(1);
      sync_in = 1'b0;
      clk_en = 1'b0;
      check(cnt, 32'h100);
      check(sync_out, 32'h1);
      cyc(5);
      check(cnt, 32'h100);
      check(sync_out, 32'h0);
      clk_en = 1'b1;
      cyc(1);
      check(cnt, 32'h101);
      phase = 32'hFFFFFFFD;
      sync_in = 1'b1;
      cyc(1);
      sync_in = 1'b0;
      cyc(3);
      check(cnt, 32'h0);
      check(flags[4], 1'b1);
      check(sync_out, 32'h1);
   endtask
   task automatic t_pwm();
      int highs;
      highs = 0;
      mode = 1'b1;
      sh_per = 32'h9;
      sh_cmp = 32'h3;
      shw = 1'b1;
      cyc(1);
      shw = 1'b0;
      phase = 32'hFFFFFFF0;
      sync_in = 1'b1;
      cyc(1);
      sync_in = 1'b0;
      mask = 7'h20;
      cyc(12);
      check(ts[0], 32'h9);
      check(ts[1], 32'h3);
      check(ts[2], 32'h9);
      check(ts[3], 32'h3);
      for (int k = 0; k < 20; k++) begin
         if (pwm === 1'b1) highs++;
         cyc(1);
      end
      check(highs, 32'h8);
      check(flags[6:5], 2'h3);
      check(irq, 1'b1);
      check(idx, 2'h2);
   endtask
   initial begin
      cyc(4);
      rst = 1'b0;
      cyc(4);
      t_capture(1'b0, 0);
      t_capture(1'b1, 1);
      t_sync_gate();
      t_pwm();
      finish_test();
   end
   initial begin
      #20us;
      errors++;
      finish_test();
   end
endmodule
